// ==== pxsig_params.svh ====
// constants for the pixel signature generator
`ifndef PXSIG_PARAMS_SVH
`define PXSIG_PARAMS_SVH
`define PXSIG_IDX_CTRL 8'h18
`define PXSIG_IDX_LOW 8'h19
`define PXSIG_IDX_HIGH 8'h1A
`define PXSIG_IDX_UNLOCK 8'h06
`define PXSIG_UNLOCK_VAL 8'h12
`define PXSIG_BIT_EN 0
`define PXSIG_BIT_RST 1
`define PXSIG_SEL_LO 2
`define PXSIG_SEL_HI 4
`define PXSIG_BIT_GEN 5
`define PXSIG_MISC_LO 6
`define PXSIG_MISC_HI 7
`define PXSIG_POLY 16'h1021
`define PXSIG_SEED 16'h0000
`define PXSIG_GEN_SEED 8'h01
`define PXSIG_CTRL_RST 8'h00
`endif

// ==== pxsig_pkg.sv ====
// types for the pixel signature generator
package pxsig_pkg;
   typedef enum logic [1:0] {
      PXSIG_IDLE = 2'b00,
      PXSIG_ARMED = 2'b01,
      PXSIG_RUN = 2'b10
   } pxsig_state_type;
endpackage : pxsig_pkg

// ==== pxsig_frame_checksum_unit.sv ====
// pixel signature generator: register port, frame sequencer and 16-bit signature register
`timescale 1ns/10ps
`include "pxsig_params.svh"
module pxsig_frame_checksum_unit
   import pxsig_pkg::*;
#(
   parameter int PIX_W = 8 // width of the displayed pixel bus
) (
   input wire logic clk, // system / pixel clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic idx_wr, // write strobe of the index port
   input wire logic data_wr, // write strobe of the data port
   input wire logic data_rd, // read strobe of the data port
   input wire logic [7:0] wdata, // write data for both ports
   output logic [7:0] rdata, // data port read value, registered
   output logic [7:0] index_q, // current index port contents
   input wire logic vsync, // vertical sync, active high
   input wire logic pix_valid, // displayed pixel present this cycle
   input wire logic [PIX_W-1:0] pix_data, // final displayed pixel after blink and cursor
   output logic [PIX_W-1:0] test_pix, // factory test data, valid when gen enabled
   output logic gen_en, // factory test data generator enabled
   output logic [1:0] ctrl_misc // control bits 7:6 for other logic
);

   // refuse pixel bus widths that the three-bit select cannot serve
   if (PIX_W != 8) begin : g_bad_width
      $error("pixel bus must be 8 bits");
   end

   typedef struct packed {
      logic [7:0] index_r;
      logic unlock_r;
      logic [1:0] misc_r;
      logic gen_r;
      logic [2:0] sel_r;
      logic rst_r;
      logic en_r;
      pxsig_state_type st_r;
      logic vs_d_r;
      logic [15:0] lfsr_r;
      logic [15:0] result_r;
      logic [7:0] gen_data_r;
      logic [7:0] rdata_r;
   } pxsig_regs_type;

   pxsig_regs_type q_r;
   pxsig_regs_type q_nxt;
   logic vs_rise;
   logic frame_end;
   logic sig_bit;
   logic fb;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      q_nxt = q_r;
      vs_rise = vsync & ~q_r.vs_d_r;
      frame_end = vs_rise;
      // pick one bit of the displayed stream, or of the test pattern
      sig_bit = q_r.gen_r ? q_r.gen_data_r[q_r.sel_r] : pix_data[q_r.sel_r];
      fb = q_r.lfsr_r[15] ^ sig_bit;
      q_nxt.vs_d_r = vsync;
      // test data generator: free running counter pattern
      if (q_r.gen_r) begin
         q_nxt.gen_data_r = q_r.gen_data_r + 8'h01;
      end else begin
         q_nxt.gen_data_r = `PXSIG_GEN_SEED;
      end
      // index port
      if (idx_wr) begin
         q_nxt.index_r = wdata;
      end
      // data port writes
      if (data_wr) begin
         if (q_r.index_r == `PXSIG_IDX_UNLOCK) begin
            q_nxt.unlock_r = (wdata == `PXSIG_UNLOCK_VAL);
         end else if (q_r.unlock_r && q_r.index_r == `PXSIG_IDX_CTRL) begin
            q_nxt.misc_r = wdata[`PXSIG_MISC_HI:`PXSIG_MISC_LO];
            q_nxt.gen_r = wdata[`PXSIG_BIT_GEN];
            q_nxt.sel_r = wdata[`PXSIG_SEL_HI:`PXSIG_SEL_LO];
            q_nxt.rst_r = wdata[`PXSIG_BIT_RST];
            if (wdata[`PXSIG_BIT_EN]) begin
               q_nxt.en_r = 1'b1;
            end
         end
      end
      // frame sequencer
      unique case (q_r.st_r)
         PXSIG_IDLE: begin
            if (q_nxt.en_r && !q_r.en_r && !q_nxt.rst_r) begin
               q_nxt.st_r = PXSIG_ARMED;
            end
         end
         PXSIG_ARMED: begin
            if (vs_rise) begin
               q_nxt.st_r = PXSIG_RUN;
               q_nxt.lfsr_r = `PXSIG_SEED;
            end
         end
         PXSIG_RUN: begin
            if (frame_end) begin
               q_nxt.st_r = PXSIG_IDLE;
               q_nxt.result_r = q_r.lfsr_r;
               q_nxt.en_r = 1'b0;
            end else if (pix_valid) begin
               // galois step with the fixed polynomial
               q_nxt.lfsr_r = {q_r.lfsr_r[14:0], 1'b0} ^ (fb ? `PXSIG_POLY : 16'h0000);
            end
         end
         default: q_nxt.st_r = PXSIG_IDLE;
      endcase
      // reset bit holds the logic and clears the accumulator
      if (q_r.rst_r) begin
         q_nxt.lfsr_r = `PXSIG_SEED;
         q_nxt.st_r = PXSIG_IDLE;
         if (!(data_wr && q_r.index_r == `PXSIG_IDX_CTRL)) begin
            q_nxt.en_r = 1'b0;
         end
      end
      // read data
      if (data_rd) begin
         unique case (q_r.index_r)
            `PXSIG_IDX_CTRL: q_nxt.rdata_r = {q_r.misc_r, q_r.gen_r, q_r.sel_r,
                                            q_r.rst_r, q_r.en_r};
            `PXSIG_IDX_LOW: q_nxt.rdata_r = q_r.result_r[7:0];
            `PXSIG_IDX_HIGH: q_nxt.rdata_r = q_r.result_r[15:8];
            `PXSIG_IDX_UNLOCK: q_nxt.rdata_r = {7'h00, q_r.unlock_r};
            default: q_nxt.rdata_r = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_r <= '0;
         q_r.st_r <= PXSIG_IDLE;
         q_r.gen_data_r <= `PXSIG_GEN_SEED;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs
   assign rdata = q_r.rdata_r;
   assign index_q = q_r.index_r;
   assign test_pix = q_r.gen_data_r;
   assign gen_en = q_r.gen_r;
   assign ctrl_misc = q_r.misc_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence pxsig_run_end_s;
      q_r.st_r == PXSIG_RUN && vsync && !q_r.vs_d_r && !q_r.rst_r;
   endsequence

   done_clears_en_a: assert property (@(posedge clk) disable iff (sys_rst)
      pxsig_run_end_s |=> !q_r.en_r && q_r.st_r == PXSIG_IDLE)
      else $error("enable not cleared at frame end");

   result_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
      pxsig_run_end_s |=> q_r.result_r == $past(q_r.lfsr_r))
      else $error("result not captured at frame end");

   reset_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.rst_r |=> q_r.lfsr_r == `PXSIG_SEED && q_r.st_r == PXSIG_IDLE)
      else $error("reset bit did not clear accumulator");

   arm_waits_vs_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r == PXSIG_ARMED && !(vsync && !q_r.vs_d_r) && !q_r.rst_r
      |=> q_r.st_r == PXSIG_ARMED)
      else $error("armed state left without sync");

   low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && q_r.index_r == `PXSIG_IDX_LOW |=> rdata == $past(q_r.result_r[7:0]))
      else $error("low result read wrong");

   high_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && q_r.index_r == `PXSIG_IDX_HIGH |=> rdata == $past(q_r.result_r[15:8]))
      else $error("high result read wrong");

   sel_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_wr && q_r.unlock_r && q_r.index_r == `PXSIG_IDX_CTRL
      |=> q_r.sel_r == $past(wdata[4:2]) && gen_en == $past(wdata[5]))
      else $error("control fields not stored");

   misc_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
      !data_wr |=> $stable(ctrl_misc))
      else $error("misc bits changed without a write");

   lfsr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r == PXSIG_RUN && !pix_valid && !vsync && !q_r.rst_r |=> $stable(q_r.lfsr_r))
      else $error("accumulator stepped without a pixel");

   ////////////////////////////////////////////////////////////////////////////
   // further checks on register port, sequencer and signature path
   // an unlocked write to the control index
   sequence pxsig_ctrl_wr_s;
      data_wr && q_r.unlock_r && q_r.index_r == `PXSIG_IDX_CTRL;
   endsequence

   // a rising vertical sync while the reset bit is clear
   sequence pxsig_sync_s;
      vsync && !q_r.vs_d_r && !q_r.rst_r;
   endsequence

   // an arming write from idle with the reset bit clear
   sequence pxsig_arm_s;
      q_r.st_r == PXSIG_IDLE && !q_r.en_r && !q_r.rst_r && data_wr && q_r.unlock_r
      && q_r.index_r == `PXSIG_IDX_CTRL && wdata[`PXSIG_BIT_EN] && !wdata[`PXSIG_BIT_RST];
   endsequence

   // the index port keeps the last index written
   index_store_a: assert property (@(posedge clk) disable iff (sys_rst)
      idx_wr |=> index_q == $past(wdata))
      else $error("index not stored");

   // the unlock flag follows every write to the unlock index
   unlock_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_wr && q_r.index_r == `PXSIG_IDX_UNLOCK |=> q_r.unlock_r == ($past(wdata) == `PXSIG_UNLOCK_VAL))
      else $error("unlock flag wrong");

   // locked writes leave the control fields alone
   locked_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_wr && !q_r.unlock_r |=> $stable(q_r.sel_r) && $stable(gen_en))
      else $error("control changed while locked");

   // the reset bit follows the control write
   rst_store_a: assert property (@(posedge clk) disable iff (sys_rst)
      pxsig_ctrl_wr_s |=> q_r.rst_r == $past(wdata[`PXSIG_BIT_RST]))
      else $error("reset bit not stored");

   // bits 7:6 are stored untouched for other logic
   misc_store_a: assert property (@(posedge clk) disable iff (sys_rst)
      pxsig_ctrl_wr_s |=> ctrl_misc == $past(wdata[`PXSIG_MISC_HI:`PXSIG_MISC_LO]))
      else $error("misc bits not stored");

   // an arming write from idle sets the enable and waits for sync
   arm_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      pxsig_arm_s |=> q_r.en_r && q_r.st_r == PXSIG_ARMED)
      else $error("arming write not taken");

   // the first sync after arming starts a seeded run
   sync_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r == PXSIG_ARMED ##0 pxsig_sync_s |=> q_r.st_r == PXSIG_RUN && q_r.lfsr_r == `PXSIG_SEED)
      else $error("run not started at sync");

   // a run keeps the status bit set until its frame ends
   run_stays_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r == PXSIG_RUN && !q_r.rst_r && !(vsync && !q_r.vs_d_r) |=> q_r.st_r == PXSIG_RUN && q_r.en_r)
      else $error("run left before frame end");

   // each pixel shifts the feedback into the low bit
   lfsr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r == PXSIG_RUN && pix_valid && !vs_rise && !q_r.rst_r
      |=> q_r.lfsr_r[0] == $past(q_r.lfsr_r[15] ^ sig_bit))
      else $error("accumulator step wrong");

   // the selected bit comes from the displayed pixel in normal use
   pix_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
      !gen_en |-> sig_bit == pix_data[q_r.sel_r])
      else $error("wrong pixel bit selected");

   // the selected bit comes from the test pattern when it is enabled
   gen_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
      gen_en |-> sig_bit == test_pix[q_r.sel_r])
      else $error("wrong test bit selected");

   // the test pattern counts up while enabled
   gen_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      gen_en |=> test_pix == 8'($past(test_pix) + 8'h01))
      else $error("test pattern did not count");

   // the test pattern rests at its seed while disabled
   gen_seed_a: assert property (@(posedge clk) disable iff (sys_rst)
      !gen_en |=> test_pix == `PXSIG_GEN_SEED)
      else $error("test pattern not at seed");

   // a control read returns the status bit
   ctrl_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      data_rd && q_r.index_r == `PXSIG_IDX_CTRL |=> rdata[`PXSIG_BIT_EN] == $past(q_r.en_r))
      else $error("status bit read wrong");

   // the result changes only at the end of a run
   result_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      q_r.st_r != PXSIG_RUN || !(vsync && !q_r.vs_d_r) || q_r.rst_r |=> $stable(q_r.result_r))
      else $error("result changed outside frame end");

   // read data stands until the next read
   rdata_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !data_rd |=> $stable(rdata))
      else $error("read data changed without a read");

endmodule : pxsig_frame_checksum_unit

// ==== test_pixel_signature_generator.sv ====
// self-checking testbench for the pixel signature generator
`timescale 1ns/10ps
`include "pxsig_params.svh"
module test_pixel_signature_generator;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic idx_wr = 1'b0;
   logic data_wr = 1'b0;
   logic data_rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic vsync = 1'b0;
   logic pix_valid = 1'b0;
   logic [7:0] pix_data = 8'h00;
   logic [7:0] rdata, index_q, test_pix, rv, lo;
   logic gen_en;
   logic [1:0] ctrl_misc;
   logic [15:0] acc;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   pxsig_frame_checksum_unit DUT (.clk(clk), .sys_rst(sys_rst), .idx_wr(idx_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .index_q(index_q),
      .vsync(vsync), .pix_valid(pix_valid), .pix_data(pix_data), .test_pix(test_pix),
      .gen_en(gen_en), .ctrl_misc(ctrl_misc));
   ////////////////////////////////////////////////////////////////////////////
   // clock and cycle ceiling
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // bus and compare helpers
   task cyc;
      @(posedge clk);
      #1;
   endtask : cyc
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task put(input logic [7:0] idx, input logic [7:0] v);
      idx_wr = 1'b1;
      wdata = idx;
      cyc;
      idx_wr = 1'b0;
      data_wr = 1'b1;
      wdata = v;
      cyc;
      data_wr = 1'b0;
   endtask : put
   task get(input logic [7:0] idx, output logic [7:0] v);
      idx_wr = 1'b1;
      wdata = idx;
      cyc;
      idx_wr = 1'b0;
      data_rd = 1'b1;
      cyc;
      data_rd = 1'b0;
      cyc;
      v = rdata;
   endtask : get
   // one pixel cycle; the reference signature steps only on valid pixels
   task pix(input logic v, input logic [7:0] d, input logic [2:0] sel);
      pix_valid = v;
      pix_data = d;
      if (v) acc = {acc[14:0], 1'b0} ^ ((acc[15] ^ d[sel]) ? `PXSIG_POLY : 16'h0000);
      cyc;
   endtask : pix
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_locked;
      put(`PXSIG_IDX_CTRL, 8'hE3);
      get(`PXSIG_IDX_CTRL, rv);
      chk("locked ctrl", 16'h0000, {8'h00, rv});
      get(8'h20, rv);
      chk("unmapped", 16'h0000, {8'h00, rv});
      chk("index", 16'h0020, {8'h00, index_q});
      put(`PXSIG_IDX_UNLOCK, `PXSIG_UNLOCK_VAL);
   endtask : t_locked
   task t_misc;
      put(`PXSIG_IDX_CTRL, 8'hE0);
      chk("misc", 16'h0003, {14'h0000, ctrl_misc});
      chk("gen", 16'h0001, {15'h0000, gen_en});
      put(`PXSIG_IDX_CTRL, 8'h00);
      chk("gen off", 16'h0000, {15'h0000, gen_en});
   endtask : t_misc
   // full arm, one frame of pixels, poll and read the two result bytes
   task t_capture(input logic [2:0] sel);
      put(`PXSIG_IDX_CTRL, {3'b000, sel, 2'b10});
      put(`PXSIG_IDX_CTRL, {3'b000, sel, 2'b00});
      put(`PXSIG_IDX_CTRL, {3'b000, sel, 2'b01});
      get(`PXSIG_IDX_CTRL, rv);
      chk("armed", 16'h0001, {15'h0000, rv[0]});
      acc = `PXSIG_SEED;
      vsync = 1'b1;
      cyc;
      vsync = 1'b0;
      for (int k = 0; k < 40; k++) begin
         pix(k % 3 != 0, 8'(k * 29 + sel), sel);
      end
      pix_valid = 1'b0;
      vsync = 1'b1;
      cyc;
      vsync = 1'b0;
      for (int n = 0; n < 8 && rv[0] !== 1'b0; n++) begin
         get(`PXSIG_IDX_CTRL, rv);
      end
      chk("done", 16'h0000, {15'h0000, rv[0]});
      get(`PXSIG_IDX_LOW, lo);
      get(`PXSIG_IDX_HIGH, rv);
      chk("signature", acc, {rv, lo});
   endtask : t_capture
   ////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk("reset rdata", 16'h0000, {8'h00, rdata});
      chk("reset test_pix", 16'h0001, {8'h00, test_pix});
      t_locked;
      t_misc;
      for (int s = 0; s < 8; s++) begin
         t_capture(3'(s));
      end
      summarize;
   end
endmodule : test_pixel_signature_generator
